// File: hdl/tpsw_pkg.sv
/*
 * shared constants for the transmitter power/sleep/wake command logic:
 * command codes, field positions, reset words and timing counts.
 * assumes a single 125 MHz clock shared by host end and device end.
 */
package tpsw_pkg;
    // ************************************************************
    // command codes and reset words
    // ************************************************************
    localparam logic [7:0] TPSW_SLEEP_CODE = 8'hc4;
    localparam logic [2:0] TPSW_WAKE_CODE = 3'h7;
    localparam logic [7:0] TPSW_BATT_CODE = 8'hc2;
    localparam logic [7:0] TPSW_PWR_CODE = 8'hc0;
    localparam logic [7:0] TPSW_XMIT_CODE = 8'hc6;
    localparam logic [15:0] TPSW_SLEEP_RST = 16'hc400;
    localparam logic [15:0] TPSW_WAKE_RST = 16'he000;
    localparam logic [15:0] TPSW_BATT_RST = 16'hc200;
    localparam logic [15:0] TPSW_PWR_RST = 16'hc000;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TPSW_WAKE_EXP_HI = 12;
    localparam int TPSW_WAKE_EXP_LO = 8;
    localparam int TPSW_BATT_CODE_HI = 4;
    localparam int TPSW_BIT_AUTO_OSC = 7;
    localparam int TPSW_BIT_AUTO_AMP = 6;
    localparam int TPSW_BIT_XTAL = 5;
    localparam int TPSW_BIT_PLL = 4;
    localparam int TPSW_BIT_AMP = 3;
    localparam int TPSW_BIT_BATT = 2;
    localparam int TPSW_BIT_WAKE = 1;
    localparam int TPSW_BIT_CLKOFF = 0;
    // ************************************************************
    // battery thresholds in millivolts
    // ************************************************************
    localparam logic [12:0] TPSW_BATT_BASE_MV = 13'd2200;
    localparam logic [12:0] TPSW_BATT_STEP_MV = 13'd100;
    localparam logic [12:0] TPSW_BATT_HYST_MV = 13'd50;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int TPSW_CLK_NS = 8;
    localparam int TPSW_CAL_NS = 800;
    localparam int TPSW_CAL_CYC = (TPSW_CAL_NS + TPSW_CLK_NS - 1) / TPSW_CLK_NS;
    localparam int TPSW_XTAL_NS = 400;
    localparam int TPSW_XTAL_CYC = (TPSW_XTAL_NS + TPSW_CLK_NS - 1) / TPSW_CLK_NS;
endpackage

// File: hdl/tpsw_if.sv
/*
 * command link between host end and device end: one word strobe
 * with data. assumes both ends share clock and reset.
 */
`timescale 1ns/1ns
interface tpsw_if;
    logic cmd_valid;
    logic [15:0] cmd_word;
    modport host (output cmd_valid, output cmd_word);
    modport device (input cmd_valid, input cmd_word);
endinterface

// File: hdl/tpsw_device.sv
/*
 * device end: decodes command words and sequences oscillator,
 * synthesizer, amplifier, sleep countdown, wake timer and battery monitor.
 * assumes analog status (lock, stable, supply in mV) synchronous to clock.
 */
// Overview of operation
// - sleep code upper byte, count low byte
// - sleep: amp/pll off, count, oscillator off
// - wake word: exponent 12..8, multiplier 7..0
// - wake interval is multiplier times two^exponent
// - host re-arms wake timer after each wake event
// - host writes zero to battery bits 7..5
// - threshold is code/10 plus 2.2 V
// - low flag at 50 mV below threshold
// - monitor runs only while enable set
// - power word: auto, xtal, pll, amp, ...
// - auto: oscillator on transmit, pll when stable
// - auto amp only after pll lock
// - oscillator follows its enable bit
// - host keeps pll and xtal on manually
// - pll calibrates at power-up and re-enable
// - amp bit drives amplifier directly
// - wake bit starts and stops timer
// - clock-out disable bit stops clock out
// - clock out runs after reset
// - host enables amp before transmit
`timescale 1ns/1ns
module tpsw_device import tpsw_pkg::*; #(
    parameter int WAKE_W = 40
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    tpsw_if.device link,
    input wire logic xtal_stable,
    input wire logic pll_locked,
    input wire logic [12:0] supply_mv,
    output logic xtal_run,
    output logic pll_run,
    output logic amp_run,
    output logic pll_calibrating,
    output logic clock_out_run,
    output logic sleeping,
    output logic battery_low,
    output logic wake_event,
    output logic [15:0] status_word
);
    // refuse counters too narrow for the longest interval
    if (WAKE_W < 39) begin : g_wake_w_check
        $error("wake counter too narrow for 255*2^31");
    end

    typedef enum logic [1:0] {TPSW_AWAKE = 2'b00, TPSW_DRAIN = 2'b01, TPSW_ASLEEP = 2'b11} tpsw_slp_t;
    typedef enum logic [1:0] {TPSW_IDLE = 2'b00, TPSW_XSTART = 2'b01, TPSW_PSTART = 2'b11} tpsw_auto_t;

    logic [15:0] sleep_cycle_count_r, wake_interval_r, battery_threshold_r, power_enables_r;
    logic hit_sleep, hit_wake, hit_batt, hit_pwr, hit_xmit;
    tpsw_slp_t slp_r;
    tpsw_auto_t auto_r;
    logic [7:0] drain_cnt_r;
    logic [7:0] cal_cnt_r;
    logic pll_run_q_r;
    logic [WAKE_W-1:0] wake_cnt_r;
    logic wake_on_q_r;
    logic [12:0] thresh_mv;
    logic auto_xtal, auto_pll, pll_any;

    // ************************************************************
    // command decode
    // ************************************************************
    // code matching
    assign hit_sleep = link.cmd_valid && link.cmd_word[15:8] == TPSW_SLEEP_CODE;
    assign hit_wake = link.cmd_valid && link.cmd_word[15:13] == TPSW_WAKE_CODE;
    assign hit_batt = link.cmd_valid && link.cmd_word[15:8] == TPSW_BATT_CODE;
    assign hit_pwr = link.cmd_valid && link.cmd_word[15:8] == TPSW_PWR_CODE;
    assign hit_xmit = link.cmd_valid && link.cmd_word[15:8] == TPSW_XMIT_CODE;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sleep_cycle_count_r <= TPSW_SLEEP_RST;
            wake_interval_r <= TPSW_WAKE_RST;
            battery_threshold_r <= TPSW_BATT_RST;
            power_enables_r <= TPSW_PWR_RST;
        end else if (clk_en) begin
            if (hit_sleep) sleep_cycle_count_r <= link.cmd_word;
            if (hit_wake) wake_interval_r <= link.cmd_word;
            if (hit_batt) battery_threshold_r <= link.cmd_word;
            if (hit_pwr) power_enables_r <= link.cmd_word;
        end
    end

    // ************************************************************
    // sleep sequence
    // ************************************************************
    // countdown then oscillator off
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            slp_r <= TPSW_AWAKE;
            drain_cnt_r <= 8'h00;
        end else if (clk_en) begin
            case (slp_r)
                TPSW_AWAKE: begin
                    if (hit_sleep) begin
                        drain_cnt_r <= link.cmd_word[7:0];
                        slp_r <= link.cmd_word[7:0] == 8'h00 ? TPSW_ASLEEP : TPSW_DRAIN;
                    end
                end
                TPSW_DRAIN: begin
                    drain_cnt_r <= drain_cnt_r - 8'h01;
                    if (drain_cnt_r == 8'h01) slp_r <= TPSW_ASLEEP;
                end
                TPSW_ASLEEP: begin
                    // any power word wakes the part again
                    if (hit_pwr || hit_xmit) slp_r <= TPSW_AWAKE;
                end
                default: slp_r <= TPSW_AWAKE;
            endcase
        end
    end
    assign sleeping = slp_r == TPSW_ASLEEP;

    // ************************************************************
    // automatic transmit chain
    // ************************************************************
    // oscillator first, pll when stable
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            auto_r <= TPSW_IDLE;
        end else if (clk_en) begin
            case (auto_r)
                TPSW_IDLE: if (hit_xmit && power_enables_r[TPSW_BIT_AUTO_OSC]) auto_r <= TPSW_XSTART;
                TPSW_XSTART: if (xtal_stable) auto_r <= TPSW_PSTART;
                TPSW_PSTART: ;
                default: auto_r <= TPSW_IDLE;
            endcase
            if (!power_enables_r[TPSW_BIT_AUTO_OSC] || hit_sleep) auto_r <= TPSW_IDLE;
        end
    end
    assign auto_xtal = auto_r != TPSW_IDLE;
    assign auto_pll = auto_r == TPSW_PSTART;

    // amp and pll drop at once on sleep
    always_comb begin
        xtal_run = (power_enables_r[TPSW_BIT_XTAL] || auto_xtal || slp_r == TPSW_DRAIN) && !sleeping;
        pll_any = (power_enables_r[TPSW_BIT_PLL] || auto_pll) && slp_r == TPSW_AWAKE && !hit_sleep;
        amp_run = (power_enables_r[TPSW_BIT_AMP] || (power_enables_r[TPSW_BIT_AUTO_AMP] && pll_locked))
                  && slp_r == TPSW_AWAKE && !hit_sleep;
        clock_out_run = !power_enables_r[TPSW_BIT_CLKOFF] && !sleeping;
    end

    // ************************************************************
    // synthesizer calibration
    // ************************************************************
    // calibrate on first and each re-enable; reset clears pll_run_q
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pll_run_q_r <= 1'b0;
            cal_cnt_r <= 8'h00;
        end else if (clk_en) begin
            pll_run_q_r <= pll_any;
            if (pll_any && !pll_run_q_r) cal_cnt_r <= 8'(TPSW_CAL_CYC);
            else if (!pll_any) cal_cnt_r <= 8'h00;
            else if (cal_cnt_r != 8'h00) cal_cnt_r <= cal_cnt_r - 8'h01;
        end
    end
    assign pll_run = pll_any;
    assign pll_calibrating = cal_cnt_r != 8'h00;

    // ************************************************************
    // wake timer
    // ************************************************************
    // load multiplier shifted by exponent on rising enable
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wake_cnt_r <= '0;
            wake_on_q_r <= 1'b0;
            wake_event <= 1'b0;
        end else if (clk_en) begin
            wake_on_q_r <= power_enables_r[TPSW_BIT_WAKE];
            wake_event <= 1'b0;
            if (!power_enables_r[TPSW_BIT_WAKE]) begin
                wake_cnt_r <= '0;
            end else if (!wake_on_q_r) begin
                wake_cnt_r <= WAKE_W'({wake_interval_r[7:0]}) <<
                              wake_interval_r[TPSW_WAKE_EXP_HI:TPSW_WAKE_EXP_LO];
            end else if (wake_cnt_r != '0) begin
                wake_cnt_r <= wake_cnt_r - WAKE_W'(1);
                // host must clear/set enable to re-arm
                if (wake_cnt_r == WAKE_W'(1)) wake_event <= 1'b1;
            end
        end
    end

    // ************************************************************
    // battery monitor
    // ************************************************************
    // threshold in millivolts
    assign thresh_mv = TPSW_BATT_BASE_MV +
                       13'(battery_threshold_r[TPSW_BATT_CODE_HI:0]) * TPSW_BATT_STEP_MV;
    // flag only while enabled, 50 mV under
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            battery_low <= 1'b0;
        end else if (clk_en) begin
            // one extra bit so a full-scale supply cannot wrap
            battery_low <= power_enables_r[TPSW_BIT_BATT] && !sleeping &&
                           ({1'b0, supply_mv} + {1'b0, TPSW_BATT_HYST_MV} < {1'b0, thresh_mv});
        end
    end

    // status word: bit 5 low battery, bit 0 wake event (one-cycle pulse, not held), bit 1 sleeping
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            status_word <= 16'h0000;
        end else if (clk_en) begin
            status_word <= {10'h000, battery_low, 3'h0, sleeping, wake_event};
        end
    end
endmodule

// File: hdl/tpsw_host.sv
/*
 * host end: turns user requests into command words on the link.
 * assumes the user holds each request for one cycle and supplies
 * fields already legal; reserved battery bits are forced to zero.
 */
`timescale 1ns/1ns
module tpsw_host import tpsw_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic clk_en,
    tpsw_if.host link,
    input wire logic req_sleep,
    input wire logic [7:0] sleep_count,
    input wire logic req_wake,
    input wire logic [4:0] wake_exp,
    input wire logic [7:0] wake_factor,
    input wire logic req_batt,
    input wire logic [4:0] battery_threshold_code,
    input wire logic req_pwr,
    input wire logic [7:0] pwr_bits,
    input wire logic req_xmit,
    input wire logic wake_seen,
    output logic busy
);
    logic [7:0] pwr_r;
    logic rearm_r;

    // ************************************************************
    // word builder, one word per cycle, lowest request first
    // ************************************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            link.cmd_valid <= 1'b0;
            link.cmd_word <= 16'h0000;
            pwr_r <= TPSW_PWR_RST[7:0];
            rearm_r <= 1'b0;
        end else if (clk_en) begin
            link.cmd_valid <= 1'b0;
            if (rearm_r) begin
                link.cmd_valid <= 1'b1;
                link.cmd_word <= {TPSW_PWR_CODE, pwr_r};
                rearm_r <= 1'b0;
            end else if (wake_seen && pwr_r[TPSW_BIT_WAKE]) begin
                link.cmd_valid <= 1'b1;
                link.cmd_word <= {TPSW_PWR_CODE, pwr_r & ~8'(1 << TPSW_BIT_WAKE)};
                rearm_r <= 1'b1;
            end else if (req_sleep) begin
                link.cmd_valid <= 1'b1;
                link.cmd_word <= {TPSW_SLEEP_CODE, sleep_count};
            end else if (req_wake) begin
                link.cmd_valid <= 1'b1;
                link.cmd_word <= {TPSW_WAKE_CODE, wake_exp, wake_factor};
            end else if (req_batt) begin
                link.cmd_valid <= 1'b1;
                link.cmd_word <= {TPSW_BATT_CODE, 3'h0, battery_threshold_code};
            end else if (req_pwr) begin
                link.cmd_valid <= 1'b1;
                link.cmd_word <= {TPSW_PWR_CODE, pwr_bits | (pwr_bits[TPSW_BIT_PLL] ? 8'(1 << TPSW_BIT_XTAL) : 8'h00)};
                pwr_r <= pwr_bits | (pwr_bits[TPSW_BIT_PLL] ? 8'(1 << TPSW_BIT_XTAL) : 8'h00);
            end else if (req_xmit && (pwr_r[TPSW_BIT_AMP] || pwr_r[TPSW_BIT_AUTO_AMP])) begin
                link.cmd_valid <= 1'b1;
                link.cmd_word <= {TPSW_XMIT_CODE, 8'h00};
            end
        end
    end
    // high exactly when the next edge serves the re-arm, not a request
    assign busy = rearm_r || (wake_seen && pwr_r[TPSW_BIT_WAKE]);
endmodule

// File: verification/tpsw_properties.sv
/*
 * concurrent checks on the command link and the device outputs.
 * assumes it sits beside the link in tb_top; clk_en only drops
 * while the link is idle and no calibration runs.
 */
`timescale 1ns/1ns
module tpsw_properties import tpsw_pkg::*; (
    input wire logic clock,
    input wire logic reset,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic xtal_stable,
    input wire logic pll_locked,
    input wire logic xtal_run,
    input wire logic pll_run,
    input wire logic amp_run,
    input wire logic pll_calibrating,
    input wire logic clock_out_run,
    input wire logic sleeping
);
    logic [7:0] pwr_r;
    logic sleep_r;
    logic [7:0] cal_r;
    logic sleep_word;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // ************************************************************
    // shadow of the last power word
    // ************************************************************
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pwr_r <= TPSW_PWR_RST[7:0];
        end else if (cmd_valid && cmd_word[15:8] == TPSW_PWR_CODE) begin
            pwr_r <= cmd_word[7:0];
        end
    end
    assign sleep_word = cmd_valid && cmd_word[15:8] == TPSW_SLEEP_CODE;
    // sleep pending until a power or transmit word wakes
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sleep_r <= 1'b0;
        end else if (cmd_valid && cmd_word[15:8] == TPSW_SLEEP_CODE) begin
            sleep_r <= 1'b1;
        end else if (cmd_valid && (cmd_word[15:8] == TPSW_PWR_CODE || cmd_word[15:8] == TPSW_XMIT_CODE)) begin
            sleep_r <= 1'b0;
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cal_r <= 8'h00;
        end else if (pll_calibrating) begin
            cal_r <= cal_r + 8'h01;
        end else begin
            cal_r <= 8'h00;
        end
    end
    // ************************************************************
    // assertions
    // ************************************************************
    sequence drain_three;
        !sleeping[*3] ##1 sleeping;
    endsequence
    a_sleep_count: assert property (cmd_valid && cmd_word == 16'hc403 |=> drain_three)
        else $error("sleep not entered after three drain cycles");
    a_sleep_kill: assert property (sleep_r |-> !amp_run && !pll_run)
        else $error("amplifier or synthesizer on after sleep word");
    a_sleep_xtal: assert property (sleeping |-> !xtal_run && !clock_out_run)
        else $error("oscillator running while asleep");
    a_auto_pll: assert property (pll_run && !pwr_r[4] |-> xtal_stable)
        else $error("auto synthesizer on before oscillator stable");
    a_auto_amp: assert property (amp_run && !pwr_r[3] |-> pll_locked)
        else $error("auto amplifier on before lock");
    a_manual_xtal: assert property (pwr_r[5] && !sleeping |-> xtal_run)
        else $error("oscillator off while enabled");
    a_cal_start: assert property ($rose(pll_run) |-> ##[0:1] pll_calibrating)
        else $error("no calibration after synthesizer enable");
    // a synthesizer switched off cuts its calibration short
    a_cal_length: assert property ($fell(pll_calibrating) && pll_run |-> cal_r == 8'(TPSW_CAL_CYC))
        else $error("calibration length wrong");
    a_manual_amp: assert property (pwr_r[3] && !sleep_r && !sleep_word |-> amp_run)
        else $error("manual amplifier not on");
    a_manual_pll: assert property (pwr_r[4] && !sleep_r && !sleep_word |-> pll_run)
        else $error("manual synthesizer not on");
    a_batt_reserved: assert property (cmd_valid && cmd_word[15:8] == TPSW_BATT_CODE |-> cmd_word[7:5] == 3'h0)
        else $error("battery word with reserved bits set");
    a_pll_xtal: assert property (cmd_valid && cmd_word[15:8] == TPSW_PWR_CODE && cmd_word[4] |-> cmd_word[5])
        else $error("synthesizer enabled without oscillator");
    a_xmit_amp: assert property (cmd_valid && cmd_word[15:8] == TPSW_XMIT_CODE |-> pwr_r[3] || pwr_r[6])
        else $error("transmit word without amplifier enabled");
    a_clock_out: assert property (!sleeping |-> clock_out_run == !pwr_r[0])
        else $error("clock output does not follow its disable bit");
endmodule

// File: verification/tb_top.sv
/*
 * testbench: host end drives device end over the link; tests are
 * request sequences with expected device levels. assumes one clock.
 */
`timescale 1ns/1ns
module tb_top import tpsw_pkg::*; ;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic req_sleep = 1'b0, req_wake = 1'b0, req_batt = 1'b0, req_pwr = 1'b0, req_xmit = 1'b0;
    logic [7:0] sleep_count = 8'h00, wake_factor = 8'h00, pwr_bits = 8'h00;
    logic [4:0] wake_exp = 5'h00, battery_threshold_code = 5'h00;
    logic xtal_stable = 1'b1, pll_locked = 1'b1;
    logic [12:0] supply_mv = 13'd3300;
    logic clk_en = 1'b1;
    logic host_busy;
    logic [15:0] status_word;
    logic xtal_run, pll_run, amp_run, pll_calibrating, clock_out_run, sleeping, battery_low, wake_event;
    int err_count = 0, n_checks = 0, tmo = 0, n;
    tpsw_if u_tpsw_if ();
    tpsw_host u_tpsw_host (.clock(clock), .reset(reset), .clk_en(clk_en), .link(u_tpsw_if.host),
        .req_sleep(req_sleep), .sleep_count(sleep_count), .req_wake(req_wake), .wake_exp(wake_exp),
        .wake_factor(wake_factor), .req_batt(req_batt), .battery_threshold_code(battery_threshold_code),
        .req_pwr(req_pwr), .pwr_bits(pwr_bits), .req_xmit(req_xmit), .wake_seen(wake_event), .busy(host_busy));
    tpsw_device u_tpsw_device (.clock(clock), .reset(reset), .clk_en(clk_en), .link(u_tpsw_if.device),
        .xtal_stable(xtal_stable), .pll_locked(pll_locked), .supply_mv(supply_mv), .xtal_run(xtal_run),
        .pll_run(pll_run), .amp_run(amp_run), .pll_calibrating(pll_calibrating),
        .clock_out_run(clock_out_run), .sleeping(sleeping), .battery_low(battery_low),
        .wake_event(wake_event), .status_word(status_word));
    tpsw_properties u_tpsw_properties (.clock(clock), .reset(reset), .cmd_valid(u_tpsw_if.cmd_valid),
        .cmd_word(u_tpsw_if.cmd_word), .xtal_stable(xtal_stable), .pll_locked(pll_locked),
        .xtal_run(xtal_run), .pll_run(pll_run), .amp_run(amp_run), .pll_calibrating(pll_calibrating),
        .clock_out_run(clock_out_run), .sleeping(sleeping));
    initial begin
        forever #4 clock = ~clock;
    end
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic cyc(input int c);
        repeat (c) @(negedge clock);
    endtask
    // k: 0 sleep, 1 wake period, 2 battery, 3 power, else transmit
    task automatic wr(input int k, input logic [12:0] v);
        @(negedge clock);
        // a request during a re-arm would be dropped by the host
        while (host_busy) @(negedge clock);
        case (k)
            0: begin req_sleep = 1'b1; sleep_count = v[7:0]; end
            1: begin req_wake = 1'b1; wake_exp = v[12:8]; wake_factor = v[7:0]; end
            2: begin req_batt = 1'b1; battery_threshold_code = v[4:0]; end
            3: begin req_pwr = 1'b1; pwr_bits = v[7:0]; end
            default: req_xmit = 1'b1;
        endcase
        @(negedge clock);
        {req_sleep, req_wake, req_batt, req_pwr, req_xmit} = 5'h00;
    endtask
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clock) begin
        tmo++;
        if (tmo == 8000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        cyc(3);
        reset = 1'b0;
        chk(clock_out_run, 1'b1);
        chk(amp_run, 1'b0);
        chk_w(status_word, 16'h0000);
        $display("test reset done");
        wr(3, 13'h38);
        cyc(2);
        chk(xtal_run, 1'b1);
        chk(amp_run, 1'b1);
        chk(pll_calibrating, 1'b1);
        cyc(TPSW_CAL_CYC + 2);
        chk(pll_calibrating, 1'b0);
        wr(3, 13'h28);
        wr(3, 13'h38);
        cyc(2);
        chk(pll_calibrating, 1'b1);
        cyc(TPSW_CAL_CYC + 2);
        wr(3, 13'h01);
        cyc(2);
        chk(clock_out_run, 1'b0);
        chk(xtal_run, 1'b0);
        $display("test manual done");
        supply_mv = 13'd3149;
        wr(2, 13'h0a);
        wr(3, 13'h04);
        cyc(3);
        chk(battery_low, 1'b1);
        chk_w(status_word, 16'h0020);
        supply_mv = 13'd3150;
        cyc(3);
        chk(battery_low, 1'b0);
        supply_mv = 13'd3149;
        wr(3, 13'h00);
        cyc(3);
        chk(battery_low, 1'b0);
        $display("test battery done");
        // three times two squared gives twelve cycles
        wr(1, 13'h0203);
        wr(3, 13'h02);
        n = 0;
        while (wake_event !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
        chk(n >= 11 && n <= 15, 1'b1);
        chk(host_busy, 1'b1);
        // host clears and sets the enable, then a full interval again
        n = 0;
        cyc(1);
        while (wake_event !== 1'b1 && n < 60) begin
            cyc(1);
            n++;
        end
        chk(n >= 12 && n <= 20, 1'b1);
        wr(3, 13'h00);
        n = 0;
        cyc(3);
        repeat (40) begin
            cyc(1);
            if (wake_event === 1'b1) n++;
        end
        chk(n == 0, 1'b1);
        $display("test wake done");
        xtal_stable = 1'b0;
        pll_locked = 1'b0;
        wr(3, 13'hc0);
        wr(4, 13'h00);
        cyc(2);
        chk(xtal_run, 1'b1);
        chk(pll_run, 1'b0);
        xtal_stable = 1'b1;
        cyc(3);
        chk(pll_run, 1'b1);
        chk(amp_run, 1'b0);
        pll_locked = 1'b1;
        cyc(3);
        chk(amp_run, 1'b1);
        $display("test auto done");
        wr(3, 13'h38);
        cyc(2);
        wr(0, 13'h03);
        cyc(8);
        chk(sleeping, 1'b1);
        chk(xtal_run, 1'b0);
        chk(amp_run, 1'b0);
        chk_w(status_word, 16'h0002);
        wr(3, 13'h20);
        cyc(2);
        chk(sleeping, 1'b0);
        chk(xtal_run, 1'b1);
        $display("test sleep done");
        // frozen host drops the request, device keeps its state
        clk_en = 1'b0;
        wr(3, 13'h00);
        cyc(2);
        chk(xtal_run, 1'b1);
        clk_en = 1'b1;
        cyc(2);
        chk(xtal_run, 1'b1);
        $display("test freeze done");
        close_out();
    end
endmodule
